// >>> hw/uef_top.sv
// Endpoint FIFO configuration registers, buffer length counts and engine lookup
//
// Behaviour
// RL1: Firmware selects the endpoint index before touching the fill status.
// RL2: Fill status reads zero for the control endpoint.
// RL3: Firmware waits 200 ns after an IN packet write before reading status.
// RL4: Firmware waits 200 ns after an OUT interrupt before reading status.
// RL5: Fill bits 1:0 read 00 none, 01 one, 11 both filled.
// RL6: Software writes reserved bits as zero.
// RL7: A packet size write reloads that endpoint's buffer length count.
// RL8: Bits 10:0 of packet size give the FIFO size in bytes.
// RL9: Transactions field 12:11 counts packets for isochronous or interrupt only.
// RL10: Packet size applies to every endpoint except control endpoint 0.
// RL11: Software keeps all enabled buffers within 8192 bytes.
// RL12: Without suppress bit 4 an empty packet follows a finished DMA IN.
// RL13: Enable bit 3 activates the FIFO at its programmed size.
// RL14: Disable then re-enable clears the endpoint's data toggle.
// RL15: Double buffer bit 2 gives the endpoint two packet buffers.
// RL16: Type bits 1:0 pick unused, isochronous, bulk or interrupt.
// RL17: The 16-bit buffer length count holds the current packet size.
// RL18: A bus reset clears every buffer length count.
// RL19: Each data endpoint and direction keeps its own copy of the fields.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ns
`include "uef_defines.svh"
module uef_top import uef_pkg::*; (
	input wire logic CLK,
	input wire logic SRST,
	input wire logic BUS_RESET,
	input wire logic [11:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [15:0] RDATA,
	input wire logic [3:0] ENG_IDX,
	output logic ENG_ENABLE,
	output logic [1:0] ENG_KIND,
	output logic ENG_DOUBLE,
	output logic ENG_SUPPRESS,
	output logic [10:0] ENG_FIFO_SIZE,
	output logic [1:0] ENG_TRANS,
	output logic [15:0] ENG_LENGTH,
	output logic ENG_TOGGLE,
	output logic [1:0] ENG_FILL,
	input wire logic [3:0] EVT_IDX,
	input wire logic FILL_SET,
	input wire logic FILL_DRAIN,
	input wire logic DMA_IN_DONE,
	input wire logic IN_TOKEN,
	input wire logic TOGGLE_FLIP,
	input wire logic OUT_ACK,
	input wire logic [15:0] OUT_BYTES,
	output logic ZLP_SEND
);
	// ----------------------------------------
	// Storage
	// ----------------------------------------
	uef_idx_t idx;
	uef_pkt_t pkt [`UEF_ENTRIES];
	uef_ctl_t ctl [`UEF_ENTRIES];
	logic [15:0] len [`UEF_ENTRIES];
	logic [5:0] fill_rsv [`UEF_ENTRIES];
	logic clear;
	logic data_ep;
	logic eng_data_ep;
	logic wr_pkt;
	logic wr_kind;
	logic wr_len;
	logic wr_fill;
	logic [`UEF_ENTRIES-1:0] next_rearm;

	uef_evt_if ev ();

	// Chip reset and USB bus reset clear the same state
	assign clear = SRST || BUS_RESET;
	// Index bits 3:1 are the endpoint number, bit 0 the direction
	assign data_ep = idx[3:1] != 3'h0; // see RL2
	assign eng_data_ep = ENG_IDX[3:1] != 3'h0;
	assign wr_pkt = WR && data_ep && ADDR == `UEF_OFS_PKT_SIZE; // see RL10
	assign wr_kind = WR && data_ep && ADDR == `UEF_OFS_KIND;
	assign wr_len = WR && data_ep && ADDR == `UEF_OFS_LENGTH;
	assign wr_fill = WR && data_ep && ADDR == `UEF_OFS_FILL;

	// ----------------------------------------
	// Endpoint index
	// ----------------------------------------
	// Every indexed access goes through this, so firmware sets it first
	always_ff @(posedge CLK) begin
		if (clear) begin
			idx <= `UEF_RST_INDEX;
		end else if (WR && ADDR == `UEF_OFS_INDEX) begin
			idx <= WDATA[3:0]; // see RL1
		end
	end

	// ----------------------------------------
	// Per entry registers
	// ----------------------------------------
	for (genvar e = 0; e < `UEF_ENTRIES; e++) begin : g_reg
		logic sel;
		logic evt;
		assign sel = idx == uef_idx_t'(e); // see RL19
		assign evt = EVT_IDX == uef_idx_t'(e);

		always_ff @(posedge CLK) begin
			if (clear) begin
				pkt[e] <= uef_pkt_t'(`UEF_RST_WORD);
			end else if (wr_pkt && sel) begin
				// Reserved bits are stored as written
				pkt[e] <= uef_pkt_t'(WDATA); // see RL8
			end
		end

		always_ff @(posedge CLK) begin
			if (clear) begin
				ctl[e] <= uef_ctl_t'(`UEF_RST_WORD);
			end else if (wr_kind && sel) begin
				ctl[e] <= uef_ctl_t'(WDATA); // see RL16
			end
		end

		always_ff @(posedge CLK) begin
			if (clear) begin
				fill_rsv[e] <= `UEF_RST_RSV;
			end else if (wr_fill && sel) begin
				fill_rsv[e] <= WDATA[7:2];
			end
		end

		// Software writes take priority over the engine's OUT byte count
		always_ff @(posedge CLK) begin
			if (clear) begin
				len[e] <= `UEF_RST_WORD; // see RL18
			end else if (wr_pkt && sel) begin
				len[e] <= {5'h00, WDATA[`UEF_SIZE_MSB:0]}; // see RL7
			end else if (wr_len && sel) begin
				len[e] <= WDATA; // see RL17
			end else if (OUT_ACK && evt && ctl[e].enable) begin
				len[e] <= OUT_BYTES;
			end
		end

		// Enable written from low to high rearms the endpoint
		assign next_rearm[e] = wr_kind && sel && WDATA[`UEF_ENABLE_BIT] && !ctl[e].enable; // see RL14
	end

	// ----------------------------------------
	// Tracker hookup
	// ----------------------------------------
	always_comb begin
		for (int e = 0; e < `UEF_ENTRIES; e++) begin
			ev.enable[e] = ctl[e].enable; // see RL13
			ev.dbl[e] = ctl[e].dbl; // see RL15
			ev.suppress[e] = ctl[e].suppress; // see RL12
		end
	end

	assign ev.clear = clear;
	assign ev.idx = EVT_IDX;
	assign ev.fill_set = FILL_SET;
	assign ev.fill_drain = FILL_DRAIN;
	assign ev.dma_in_done = DMA_IN_DONE;
	assign ev.in_token = IN_TOKEN;
	assign ev.toggle_flip = TOGGLE_FLIP;
	assign ev.rearm = next_rearm;

	uef_tracker u_tracker (
		.clk(CLK),
		.srst(SRST),
		.ev(ev)
	);

	// ----------------------------------------
	// Register read
	// ----------------------------------------
	// Data stands one cycle after the strobe and is zero otherwise
	always_ff @(posedge CLK) begin
		if (clear || !RD) begin
			RDATA <= `UEF_RST_WORD;
		end else begin
			unique case (ADDR)
				`UEF_OFS_INDEX: begin
					RDATA <= {12'h000, idx};
				end
				`UEF_OFS_PKT_SIZE: begin
					RDATA <= data_ep ? 16'(pkt[idx]) : `UEF_RST_WORD; // see RL10
				end
				`UEF_OFS_KIND: begin
					RDATA <= data_ep ? 16'(ctl[idx]) : `UEF_RST_WORD;
				end
				`UEF_OFS_LENGTH: begin
					RDATA <= data_ep ? len[idx] : `UEF_RST_WORD;
				end
				`UEF_OFS_FILL: begin
					// Control endpoint has no meaningful fill state
					RDATA <= data_ep ? {8'h00, fill_rsv[idx], ev.fill[idx]} : `UEF_RST_WORD; // see RL2 see RL5
				end
				default: begin
					RDATA <= `UEF_RST_WORD;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Engine lookup
	// ----------------------------------------
	// One cycle of latency from ENG_IDX; control endpoint always looks disabled
	always_ff @(posedge CLK) begin
		if (clear) begin
			ENG_ENABLE <= 1'b0;
			ENG_KIND <= UEF_KIND_UNUSED;
			ENG_DOUBLE <= 1'b0;
			ENG_SUPPRESS <= 1'b0;
		end else begin
			ENG_ENABLE <= eng_data_ep && ctl[ENG_IDX].enable; // see RL13
			ENG_KIND <= eng_data_ep ? ctl[ENG_IDX].kind : UEF_KIND_UNUSED; // see RL16
			ENG_DOUBLE <= eng_data_ep && ctl[ENG_IDX].dbl; // see RL15
			ENG_SUPPRESS <= eng_data_ep && ctl[ENG_IDX].suppress;
		end
	end

	always_ff @(posedge CLK) begin
		if (clear) begin
			ENG_FIFO_SIZE <= 11'h000;
			ENG_LENGTH <= `UEF_RST_WORD;
		end else begin
			ENG_FIFO_SIZE <= eng_data_ep ? pkt[ENG_IDX].size : 11'h000; // see RL8
			ENG_LENGTH <= eng_data_ep ? len[ENG_IDX] : `UEF_RST_WORD; // see RL17
		end
	end

	// Extra packets only mean something on isochronous or interrupt endpoints
	always_ff @(posedge CLK) begin
		if (clear) begin
			ENG_TRANS <= UEF_TRANS_ONE;
		end else if (eng_data_ep && (ctl[ENG_IDX].kind == UEF_KIND_ISO || ctl[ENG_IDX].kind == UEF_KIND_INTR)) begin
			ENG_TRANS <= pkt[ENG_IDX].trans; // see RL9
		end else begin
			ENG_TRANS <= UEF_TRANS_ONE;
		end
	end

	always_ff @(posedge CLK) begin
		if (clear) begin
			ENG_TOGGLE <= 1'b0;
			ENG_FILL <= `UEF_FILL_NONE;
		end else begin
			ENG_TOGGLE <= ev.toggle[ENG_IDX]; // see RL14
			ENG_FILL <= eng_data_ep ? ev.fill[ENG_IDX] : `UEF_FILL_NONE;
		end
	end

	// ----------------------------------------
	// Empty packet request
	// ----------------------------------------
	always_ff @(posedge CLK) begin
		if (clear) begin
			ZLP_SEND <= 1'b0;
		end else begin
			ZLP_SEND <= ev.zlp; // see RL12
		end
	end
endmodule

// >>> hw/uef_defines.svh
// Offsets, field positions, reset values and timing counts of the endpoint FIFO configuration block
`ifndef UEF_DEFINES_SVH
`define UEF_DEFINES_SVH

// ----------------------------------------
// Offsets
// ----------------------------------------
`define UEF_OFS_PKT_SIZE 12'h204
`define UEF_OFS_KIND 12'h208
`define UEF_OFS_LENGTH 12'h21c
`define UEF_OFS_FILL 12'h21e
`define UEF_OFS_INDEX 12'h22c

// ----------------------------------------
// Fields
// ----------------------------------------
`define UEF_ENTRIES 16
`define UEF_SIZE_MSB 10
`define UEF_SUPPRESS_BIT 4
`define UEF_ENABLE_BIT 3
`define UEF_FILL_NONE 2'h0
`define UEF_FILL_ONE 2'h1
`define UEF_FILL_BOTH 2'h3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define UEF_RST_WORD 16'h0000
`define UEF_RST_RSV 6'h00
`define UEF_RST_INDEX 4'h0

// ----------------------------------------
// Timing
// ----------------------------------------
`define UEF_CLK_NS 4
`define UEF_SETTLE_NS 200
`define UEF_SETTLE_CYC ((`UEF_SETTLE_NS + `UEF_CLK_NS - 1) / `UEF_CLK_NS)

`endif

// >>> hw/uef_pkg.sv
// Types of the endpoint FIFO configuration block
package uef_pkg;
	typedef logic [3:0] uef_idx_t;
	typedef enum logic [1:0] {
		UEF_KIND_UNUSED = 2'h0,
		UEF_KIND_ISO = 2'h1,
		UEF_KIND_BULK = 2'h2,
		UEF_KIND_INTR = 2'h3
	} uef_kind_t;
	typedef enum logic [1:0] {
		UEF_TRANS_ONE = 2'h0,
		UEF_TRANS_TWO = 2'h1,
		UEF_TRANS_THREE = 2'h2,
		UEF_TRANS_RSV = 2'h3
	} uef_trans_t;
	typedef struct packed {
		logic [2:0] rsv;
		uef_trans_t trans;
		logic [10:0] size;
	} uef_pkt_t;
	typedef struct packed {
		logic [10:0] rsv;
		logic suppress;
		logic enable;
		logic dbl;
		uef_kind_t kind;
	} uef_ctl_t;
endpackage

// >>> hw/uef_evt_if.sv
// Event and status carrier between the register file and the fill tracker
`timescale 1ns/1ns
`include "uef_defines.svh"
interface uef_evt_if;
	import uef_pkg::*;
	logic clear;
	uef_idx_t idx;
	logic fill_set;
	logic fill_drain;
	logic dma_in_done;
	logic in_token;
	logic toggle_flip;
	logic [`UEF_ENTRIES-1:0] enable;
	logic [`UEF_ENTRIES-1:0] dbl;
	logic [`UEF_ENTRIES-1:0] suppress;
	logic [`UEF_ENTRIES-1:0] rearm;
	logic [1:0] fill [`UEF_ENTRIES];
	logic toggle [`UEF_ENTRIES];
	logic zlp;
	modport ctrl (output clear, idx, fill_set, fill_drain, dma_in_done, in_token, toggle_flip,
		enable, dbl, suppress, rearm, input fill, toggle, zlp);
	modport trk (input clear, idx, fill_set, fill_drain, dma_in_done, in_token, toggle_flip,
		enable, dbl, suppress, rearm, output fill, toggle, zlp);
endinterface

// >>> hw/uef_tracker.sv
// Per-entry buffer fill, data toggle and pending empty packet tracking
`timescale 1ns/1ns
`include "uef_defines.svh"
module uef_tracker import uef_pkg::*; (
	input wire logic clk,
	input wire logic srst,
	uef_evt_if.trk ev
);
	logic pend [`UEF_ENTRIES];

	// ----------------------------------------
	// Per entry state
	// ----------------------------------------
	for (genvar e = 0; e < `UEF_ENTRIES; e++) begin : g_ent
		logic hit;
		logic up;
		logic down;
		assign hit = ev.idx == uef_idx_t'(e);
		// Second buffer only counts when double buffering is on
		assign up = hit && ev.fill_set && (ev.fill[e] == `UEF_FILL_NONE ||
			(ev.dbl[e] && ev.fill[e] == `UEF_FILL_ONE));
		assign down = hit && ev.fill_drain && ev.fill[e] != `UEF_FILL_NONE;

		always_ff @(posedge clk) begin
			if (srst || ev.clear || !ev.enable[e]) begin
				ev.fill[e] <= `UEF_FILL_NONE; // see RL13
			end else if (up && !down) begin
				ev.fill[e] <= (ev.fill[e] == `UEF_FILL_NONE) ? `UEF_FILL_ONE : `UEF_FILL_BOTH; // see RL15
			end else if (down && !up) begin
				ev.fill[e] <= (ev.fill[e] == `UEF_FILL_BOTH) ? `UEF_FILL_ONE : `UEF_FILL_NONE; // see RL5
			end
		end

		always_ff @(posedge clk) begin
			if (srst || ev.clear || ev.rearm[e]) begin
				ev.toggle[e] <= 1'b0; // see RL14
			end else if (hit && ev.toggle_flip) begin
				ev.toggle[e] <= !ev.toggle[e];
			end
		end

		// Set wins when the DMA finishes on the same cycle as the token
		always_ff @(posedge clk) begin
			if (srst || ev.clear || !ev.enable[e]) begin
				pend[e] <= 1'b0;
			end else if (hit && ev.dma_in_done && !ev.suppress[e]) begin
				pend[e] <= 1'b1; // see RL12
			end else if (hit && ev.in_token) begin
				pend[e] <= 1'b0;
			end
		end
	end

	assign ev.zlp = ev.in_token && pend[ev.idx] && ev.enable[ev.idx]; // see RL12
endmodule

// >>> bench/uef_top_chk.sv
// Assertion checker for the endpoint FIFO configuration block
`timescale 1ns/1ns
module uef_top_chk (
	input wire logic CLK,
	input wire logic SRST,
	input wire logic BUS_RESET,
	input wire logic [11:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [15:0] RDATA,
	input wire logic [3:0] ENG_IDX,
	input wire logic ENG_ENABLE,
	input wire logic [1:0] ENG_KIND,
	input wire logic [1:0] ENG_TRANS,
	input wire logic [15:0] ENG_LENGTH,
	input wire logic [1:0] ENG_FILL,
	input wire logic IN_TOKEN,
	input wire logic ZLP_SEND
);
	// ----------------------------------------
	// Index shadow
	// ----------------------------------------
	logic [3:0] idx;
	always_ff @(posedge CLK) begin
		if (SRST || BUS_RESET) begin
			idx <= 4'h0;
		end else if (WR && ADDR == 12'h22c) begin
			idx <= WDATA[3:0];
		end
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (SRST || BUS_RESET);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	AST_RD_IDLE: assert property (!$past(RD) |-> RDATA == 16'h0000)
		else $error("read data outside read slot");
	AST_LEN_RELOAD: assert property (WR && ADDR == 12'h204 && idx[3:1] != 3'h0 ##1 RD && ADDR == 12'h21c
		|=> RDATA == {5'h00, $past(WDATA[10:0], 2)}) else $error("length not reloaded");
	AST_ZLP: assert property (ZLP_SEND |-> $past(IN_TOKEN)) else $error("empty packet without token");
	AST_FILL_ENC: assert property (ENG_FILL != 2'h2) else $error("fill code unused");
	AST_EP0: assert property ($past(ENG_IDX[3:1]) == 3'h0 |-> !ENG_ENABLE && ENG_KIND == 2'h0
		&& ENG_FILL == 2'h0) else $error("control endpoint not inert");
	AST_TRANS_GATE: assert property (!ENG_KIND[0] |-> ENG_TRANS == 2'h0) else $error("trans not gated");
	AST_BUS_RST: assert property ($past(BUS_RESET) |-> ENG_LENGTH == 16'h0000) else $error("length kept");
	AST_FILL_HI: assert property ($past(RD) && $past(ADDR) == 12'h21e |-> RDATA[15:8] == 8'h00)
		else $error("fill upper byte set");
	cover property (ZLP_SEND);
	cover property (ENG_FILL == 2'h3);
	cover property (WR && ADDR == 12'h204);
endmodule
bind uef_top uef_top_chk chk_u (.CLK, .SRST, .BUS_RESET, .ADDR, .WDATA, .WR, .RD, .RDATA, .ENG_IDX,
	.ENG_ENABLE, .ENG_KIND, .ENG_TRANS, .ENG_LENGTH, .ENG_FILL, .IN_TOKEN, .ZLP_SEND);

// >>> bench/uef_host_model.sv
// Host side event source for the endpoint FIFO configuration block
`timescale 1ns/1ns
module uef_host_model (
	input wire logic clk,
	output logic [3:0] evt_idx,
	output logic [5:0] evt,
	output logic [15:0] out_bytes
);
	// ----------------------------------------
	// Events
	// ----------------------------------------
	initial begin
		evt_idx = 4'h0;
		evt = 6'h00;
		out_bytes = 16'h0000;
	end
	// Random gap: host answers promptly or slowly
	task send(input int k, input logic [3:0] i);
		repeat (1 + $urandom_range(3)) @(posedge clk);
		evt_idx <= i;
		evt <= 6'h01 << k; // One event line, bit k, per call
		out_bytes <= 16'($urandom);
		@(posedge clk);
		evt <= 6'h00;
		// Released lines do not keep the last value
		evt_idx <= ~i;
		out_bytes <= ~out_bytes;
	endtask
endmodule

// >>> bench/tb_uef_top.sv
// Self-checking bench for the endpoint FIFO configuration block
`timescale 1ns/1ns
`include "uef_defines.svh"
module tb_uef_top;
	logic CLK = 1'b0, SRST = 1'b1, BUS_RESET = 1'b0, WR = 1'b0, RD = 1'b0, rd_d = 1'b0;
	logic [11:0] ADDR = 12'h000;
	logic [15:0] WDATA = 16'h0000, RDATA, ENG_LENGTH, OUT_BYTES;
	logic [3:0] ENG_IDX = 4'h0, EVT_IDX;
	logic [5:0] evt;
	logic [1:0] ENG_KIND, ENG_TRANS, ENG_FILL;
	logic [10:0] ENG_FIFO_SIZE;
	logic ENG_ENABLE, ENG_DOUBLE, ENG_SUPPRESS, ENG_TOGGLE, ZLP_SEND;
	logic [15:0] exp_q[$];
	logic [15:0] pkt[16];
	logic [1:0] fl[8] = '{2'h1, 2'h3, 2'h3, 2'h1, 2'h0, 2'h0, 2'h1, 2'h1};
	int n_fail = 0, cmp_count = 0, t;
	uef_host_model host_u (.clk(CLK), .evt_idx(EVT_IDX), .evt(evt), .out_bytes(OUT_BYTES));
	uef_top dut_u (.CLK, .SRST, .BUS_RESET, .ADDR, .WDATA, .WR, .RD, .RDATA, .ENG_IDX, .ENG_ENABLE, .ENG_KIND,
		.ENG_DOUBLE, .ENG_SUPPRESS, .ENG_FIFO_SIZE, .ENG_TRANS, .ENG_LENGTH, .ENG_TOGGLE, .ENG_FILL, .EVT_IDX,
		.FILL_SET(evt[0]), .FILL_DRAIN(evt[1]), .DMA_IN_DONE(evt[2]), .IN_TOKEN(evt[3]), .TOGGLE_FLIP(evt[4]),
		.OUT_ACK(evt[5]), .OUT_BYTES, .ZLP_SEND);
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	initial begin
		forever #2 CLK = ~CLK;
	end
	task report_and_stop;
		$display("checks %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#100000;
		n_fail++;
		report_and_stop();
	end
	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask
	// Reads carry the expected word in d
	task op(input logic w, input logic r, input logic [11:0] a, input logic [15:0] d);
		WR <= w;
		RD <= r;
		ADDR <= a;
		WDATA <= d;
		if (r) exp_q.push_back(d);
		@(posedge CLK);
	endtask
	task look(input logic [3:0] i);
		ENG_IDX <= i;
		op(0, 0, 12'h000, 16'h0000);
		repeat (2) @(posedge CLK);
	endtask
	task zwait(input logic e);
		t = 0;
		repeat (4) begin
			@(posedge CLK);
			if (ZLP_SEND === 1'b1) t = 1;
		end
		chk("ZLP_SEND", 16'(e), 16'(t));
		if (e && t == 0) report_and_stop();
	endtask
	always @(posedge CLK) begin
		if (rd_d) begin
			if (exp_q.size() == 0) chk("queue", 16'h0001, 16'h0000);
			else chk("RDATA", exp_q.pop_front(), RDATA);
		end
		rd_d <= RD;
	end
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		t = $urandom(5796);
		repeat (10) @(posedge CLK);
		SRST <= 1'b0;
		op(1, 0, 12'h22c, 16'h0002);
		op(0, 1, 12'h204, 16'h0000);
		op(0, 1, 12'h208, 16'h0000);
		op(0, 1, 12'h21e, 16'h0000);
		op(0, 1, 12'h21c, 16'h0000);
		op(0, 1, 12'h100, 16'h0000);
		$display("test reset done");
		for (int i = 2; i < 16; i++) begin
			pkt[i] = {3'h0, 2'($urandom_range(2)), 11'($urandom)}; // Reserved kept zero
			op(1, 0, 12'h22c, 16'(i));
			op(1, 0, 12'h204, pkt[i]);
			op(0, 1, 12'h21c, {5'h00, pkt[i][10:0]});
			op(0, 1, 12'h204, pkt[i]);
		end
		op(1, 0, 12'h21c, 16'h0005);
		op(0, 1, 12'h21c, 16'h0005);
		for (int i = 2; i < 16; i++) begin
			op(1, 0, 12'h22c, 16'(i));
			op(0, 1, 12'h204, pkt[i]);
		end
		op(1, 0, 12'h22c, 16'h0000);
		op(1, 0, 12'h204, 16'h0123);
		op(0, 1, 12'h204, 16'h0000);
		op(0, 1, 12'h21e, 16'h0000);
		$display("test sizes done");
		op(1, 0, 12'h22c, 16'h0004);
		for (int k = 0; k < 4; k++) begin
			op(1, 0, 12'h208, 16'(8 + k));
			op(0, 1, 12'h208, 16'(8 + k));
			look(4'h4);
			chk("ENG_KIND", 16'(k), 16'(ENG_KIND));
			chk("ENG_TRANS", k % 2 ? 16'(pkt[4][12:11]) : 16'h0000, 16'(ENG_TRANS));
		end
		// Only one endpoint enabled, well inside the buffer budget
		op(1, 0, 12'h208, 16'h000e);
		for (int k = 0; k < 8; k++) begin
			op(k == 6, 0, 12'h208, 16'h000a);
			host_u.send(k > 2 && k < 6, 4'h4);
			repeat (`UEF_SETTLE_CYC) @(posedge CLK);
			op(0, 1, 12'h21e, {14'h0, fl[k]});
			look(4'h4);
			chk("ENG_FILL", 16'(fl[k]), 16'(ENG_FILL));
			chk("ENG_DOUBLE", 16'(k < 6), 16'(ENG_DOUBLE));
		end
		$display("test fill done");
		op(0, 0, 12'h000, 16'h0000);
		host_u.send(2, 4'h4);
		host_u.send(3, 4'h4);
		zwait(1'b1);
		op(1, 0, 12'h208, 16'h001a);
		op(0, 0, 12'h000, 16'h0000);
		host_u.send(2, 4'h4);
		host_u.send(3, 4'h4);
		zwait(1'b0);
		host_u.send(4, 4'h4);
		look(4'h4);
		chk("ENG_TOGGLE", 16'h0001, 16'(ENG_TOGGLE));
		chk("ENG_FIFO_SIZE", 16'(pkt[4][10:0]), 16'(ENG_FIFO_SIZE));
		chk("ENG_SUPPRESS", 16'h0001, 16'(ENG_SUPPRESS));
		op(1, 0, 12'h208, 16'h0002);
		op(1, 0, 12'h208, 16'h000a);
		look(4'h4);
		chk("ENG_TOGGLE", 16'h0000, 16'(ENG_TOGGLE));
		chk("ENG_ENABLE", 16'h0001, 16'(ENG_ENABLE));
		chk("ENG_SUPPRESS", 16'h0000, 16'(ENG_SUPPRESS));
		chk("ENG_FILL", 16'h0000, 16'(ENG_FILL));
		// Host byte count still stands in the step the model returns
		host_u.send(5, 4'h4);
		t = OUT_BYTES;
		op(0, 1, 12'h21c, 16'(t));
		look(4'h4);
		chk("ENG_LENGTH", 16'(t), ENG_LENGTH);
		host_u.send(5, 4'h6);
		op(1, 0, 12'h22c, 16'h0006);
		op(0, 1, 12'h21c, {5'h00, pkt[6][10:0]});
		$display("test engine done");
		BUS_RESET <= 1'b1;
		op(0, 0, 12'h000, 16'h0000);
		BUS_RESET <= 1'b0;
		op(1, 0, 12'h22c, 16'h0004);
		op(0, 1, 12'h21c, 16'h0000);
		op(0, 1, 12'h204, 16'h0000);
		op(0, 0, 12'h000, 16'h0000);
		repeat (2) @(posedge CLK);
		$display("test bus reset done");
		report_and_stop();
	end
endmodule
